// [clock_divide_power_manager.sv]
// Power-management register with machine-cycle divider and multiplier control.
// Assumes a core on mclk_i drives the special-function bus and event pulses;
// rxd_i and ring_osc_active_i come from outside and are synchronised here.
`timescale 1ns/100ps

module clock_divide_power_manager
  import clock_power_pkg::*;
#(
  parameter int STAB_CNT = STAB_CYCLES
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Special-function register bus.
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Core events and status.
  input wire logic ring_osc_active_i,
  input wire logic stop_enter_i,
  input wire logic ext_int_active_i,
  input wire logic ext_int_ack_i,
  input wire logic serial_tx_start_i,
  input wire logic serial_tx_busy_i,
  input wire logic serial_rx_busy_i,
  input wire logic rxd_i,
  input wire logic instr_start_i,
  // Timer and serial selects.
  input wire logic timer_clock_select_i,
  input wire logic baud_doubler_i,
  // Memory access strobe request.
  input wire logic ale_req_i,
  input wire logic ext_mem_access_i,
  // Clock control outputs.
  output logic [1:0] divide_sel_o,
  output logic multiplier_enable_o,
  output logic multiplier_rate_select_o,
  output logic clock_ready_flag_o,
  output logic machine_tick_o,
  output logic timer_tick_o,
  output logic serial2_tick_o,
  // Address latch strobe.
  output logic ale_o
);

  // ----------------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------------
  // First stages are read only by the second stages.
  logic rxd_meta_reg;
  logic rxd_sync_reg;
  logic rxd_prev_reg;
  logic ring_meta_reg;
  logic ring_sync_reg;

  // Two flops for each outside level, plus a history flop for the edge detector.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxd_meta_reg <= 1'h1;
      rxd_sync_reg <= 1'h1;
      rxd_prev_reg <= 1'h1;
      ring_meta_reg <= 1'h0;
      ring_sync_reg <= 1'h0;
    end else begin
      rxd_meta_reg <= rxd_i;
      rxd_sync_reg <= rxd_meta_reg;
      rxd_prev_reg <= rxd_sync_reg;
      ring_meta_reg <= ring_osc_active_i;
      ring_sync_reg <= ring_meta_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // Register fields
  // ----------------------------------------------------------------------------
  logic [1:0] div_reg; // Divide field: divide_select_hi and divide_select_lo.
  logic swb_reg; // switchback_enable.
  logic ctm_reg; // multiplier_enable.
  logic rate_reg; // multiplier_rate_select.
  logic strobe_suppress_reg; // strobe_suppress.
  logic rx_pend_reg; // Start bit seen, waiting for the next instruction.
  logic [1:0] div_next;
  logic ctm_next;
  logic rate_next;
  logic rx_pend_next;
  logic ready;

  // Bus decode.
  wire wr_pmr = sfr_wr_i && (sfr_addr_i == PMR_ADDR);
  wire rd_pmr = sfr_rd_i && (sfr_addr_i == PMR_ADDR);
  wire [1:0] w_div = sfr_wdata_i[DIV_HI_BIT:DIV_LO_BIT];
  wire w_ctm = sfr_wdata_i[CTM_BIT];
  wire w_rate = sfr_wdata_i[RATE_BIT];
  wire [7:0] pmr_value = {div_reg, swb_reg, ctm_reg, rate_reg, strobe_suppress_reg, RESERVED_BITS};

  // ----------------------------------------------------------------------------
  // Switchback
  // ----------------------------------------------------------------------------
  wire slow_swb = swb_reg && (div_reg == DIV_BY1024);
  // A falling edge on the receive line while slow and armed is held until the
  // next instruction boundary.
  wire rx_fall = rxd_prev_reg && !rxd_sync_reg;
  // The acknowledge pulse already means the interrupt was enabled and won
  // priority, so a masked request never switches back.
  wire swb_fire = slow_swb &&
    (ext_int_ack_i || serial_tx_start_i || (rx_pend_reg && instr_start_i));
  // Anything that would switch straight back makes slow mode pointless.
  wire src_active = ext_int_active_i || serial_tx_busy_i || serial_rx_busy_i || rx_pend_reg;

  // A new edge in the firing cycle belongs to a later instruction, so set wins.
  always_comb begin
    rx_pend_next = rx_pend_reg;
    if (!slow_swb) begin
      rx_pend_next = 1'h0;
    end else if (rx_fall) begin
      rx_pend_next = 1'h1;
    end else if (swb_fire) begin
      rx_pend_next = 1'h0;
    end
  end

  // ----------------------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------------------
  // The multiplier speed also needs a running, settled multiplier; that check
  // protects the system clock when software skips the ready poll.
  wire div_route_ok = (div_reg == DIV_BY4) || (w_div == DIV_BY4);
  wire div_mult_ok = (w_div != DIV_MULT) || (!ring_sync_reg && ctm_reg && ready);
  wire div_slow_ok = (w_div != DIV_BY1024) || !(swb_reg && src_active);
  wire div_ok = (w_div != DIV_RSVD) && div_route_ok && div_mult_ok && div_slow_ok;
  wire ctm_ok = (div_reg == DIV_BY4) && !ring_sync_reg;
  wire rate_ok = !ctm_reg;
  wire ctm_start = wr_pmr && ctm_ok && w_ctm && !ctm_reg;

  // Each field is judged alone; a refused field keeps its value silently.
  always_comb begin
    div_next = div_reg;
    ctm_next = ctm_reg;
    rate_next = rate_reg;
    if (swb_fire) begin
      div_next = DIV_BY4;
    end else if (wr_pmr && div_ok) begin
      div_next = w_div;
    end
    if (stop_enter_i) begin
      ctm_next = 1'h0;
    end else if (wr_pmr && ctm_ok) begin
      ctm_next = w_ctm;
    end
    if (wr_pmr && rate_ok) begin
      rate_next = w_rate;
    end
  end

  // ----------------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------------
  // Fields and the registered read data.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= PMR_RESET[DIV_HI_BIT:DIV_LO_BIT];
      swb_reg <= PMR_RESET[SWB_BIT];
      ctm_reg <= PMR_RESET[CTM_BIT];
      rate_reg <= PMR_RESET[RATE_BIT];
      strobe_suppress_reg <= PMR_RESET[STROBE_SUPPRESS_BIT];
      rx_pend_reg <= 1'h0;
      sfr_rdata_o <= 8'h00;
    end else begin
      div_reg <= div_next;
      ctm_reg <= ctm_next;
      rate_reg <= rate_next;
      rx_pend_reg <= rx_pend_next;
      if (wr_pmr) begin
        swb_reg <= sfr_wdata_i[SWB_BIT];
        strobe_suppress_reg <= sfr_wdata_i[STROBE_SUPPRESS_BIT];
      end
      sfr_rdata_o <= rd_pmr ? pmr_value : 8'h00;
    end
  end

  // ----------------------------------------------------------------------------
  // Address latch strobe
  // ----------------------------------------------------------------------------
  // One cycle of latency, matching the request pipeline of the core.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ale_o <= 1'h0;
    end else begin
      ale_o <= ale_req_i && (ext_mem_access_i || !strobe_suppress_reg);
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs and sub-blocks
  // ----------------------------------------------------------------------------
  assign divide_sel_o = div_reg;
  assign multiplier_enable_o = ctm_reg;
  assign multiplier_rate_select_o = rate_reg;
  assign clock_ready_flag_o = ready;

  // Stabilisation wait for the multiplier.
  clock_warmup #(
    .STAB_CNT(STAB_CNT)
  ) u_warmup (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .enable_i(ctm_reg),
    .start_i(ctm_start),
    .ready_o(ready)
  );

  // Tick generation from the current settings.
  cycle_divider u_divider (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .divide_i(div_reg),
    .rate_i(rate_reg),
    .timer_sel_i(timer_clock_select_i),
    .baud_doubler_i(baud_doubler_i),
    .mc_tick_o(machine_tick_o),
    .timer_tick_o(timer_tick_o),
    .serial2_tick_o(serial2_tick_o)
  );

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_reserved_read_ones: assert property (rd_pmr |=> sfr_rdata_o[1:0] == RESERVED_BITS)
    else $error("reserved bits did not read as one");
  a_div_never_rsvd: assert property (div_reg != DIV_RSVD)
    else $error("divide field holds the reserved code");
  a_div_via_four: assert property ((div_reg != $past(div_reg)) |->
    (div_reg == DIV_BY4 || $past(div_reg) == DIV_BY4))
    else $error("divide field skipped divide-by-4");
  a_bad_route_kept: assert property ((wr_pmr && !div_route_ok && !swb_fire) |=> div_reg == $past(div_reg))
    else $error("illegal divide transition was taken");
  a_no_fast_ring: assert property ((wr_pmr && w_div == DIV_MULT && ring_sync_reg) |=> div_reg != DIV_MULT)
    else $error("multiplier speed entered on ring oscillator");
  a_slow_refused: assert property ((wr_pmr && w_div == DIV_BY1024 && swb_reg && src_active) |=>
    div_reg != DIV_BY1024)
    else $error("slow mode entered with switchback source active");
  a_switchback_four: assert property (swb_fire |=> div_reg == DIV_BY4 && (!rx_pend_reg || $past(rx_fall)))
    else $error("switchback did not return to divide-by-4");
  a_ctm_change_ok: assert property ((ctm_reg != $past(ctm_reg)) |-> ($past(stop_enter_i) ||
    ($past(div_reg) == DIV_BY4 && !$past(ring_sync_reg))))
    else $error("multiplier enable changed outside divide-by-4");
  a_stop_clears_ctm: assert property (stop_enter_i |=> !ctm_reg)
    else $error("stop did not clear multiplier enable");
  a_ready_after_en: assert property ($rose(ctm_reg) |-> !clock_ready_flag_o [*8])
    else $error("clock ready set too early after enable");
  a_rate_locked: assert property ((rate_reg != $past(rate_reg)) |-> !$past(ctm_reg))
    else $error("rate bit changed with multiplier enabled");
  a_ale_hidden: assert property ((ale_req_i && !ext_mem_access_i && strobe_suppress_reg) |=> !ale_o)
    else $error("strobe shown on internal access while suppressed");
  a_ale_external: assert property ((ale_req_i && ext_mem_access_i) |=> ale_o)
    else $error("strobe missing on external access");
  // Bus-side checks below exclude switchback and stop, which outrank a write.
  a_rsvd_write_kept: assert property ((wr_pmr && w_div == DIV_RSVD && !swb_fire) |=> div_reg == $past(div_reg))
    else $error("reserved divide code was accepted");
  a_free_bits_written: assert property (wr_pmr |=> swb_reg == $past(sfr_wdata_i[SWB_BIT]) &&
    strobe_suppress_reg == $past(sfr_wdata_i[STROBE_SUPPRESS_BIT]))
    else $error("unprotected bits were not written");
  a_ready_needs_en: assert property (!ctm_reg |=> !clock_ready_flag_o)
    else $error("clock ready shown with multiplier powered down");
  a_ctm_fast_held: assert property ((div_reg == DIV_MULT && ctm_reg && !stop_enter_i) |=> ctm_reg)
    else $error("multiplier enable cleared at multiplier speed");
  a_fast_needs_ready: assert property (($changed(div_reg) && div_reg == DIV_MULT) |-> $past(ctm_reg) && $past(ready))
    else $error("multiplier speed entered before the multiplier settled");

  // Covers show that switchback, engage, fast mode and refusal are all reached.
  c_switchback: cover property (swb_fire ##1 div_reg == DIV_BY4);
  c_rx_switchback: cover property ((rx_pend_reg && instr_start_i && slow_swb) ##1 div_reg == DIV_BY4);
  c_multiplier_on: cover property ($rose(ctm_reg) ##[1:8] ctm_reg);
  c_fast_mode: cover property ($changed(div_reg) && div_reg == DIV_MULT);
  c_refused_write: cover property (wr_pmr && !div_ok && w_div != div_reg);

endmodule

// [clock_power_pkg.sv]
// Shared constants for the machine-cycle divider and power-management block.
// Assumes a single oscillator clock domain and an 8-bit special-function bus.

package clock_power_pkg;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  // Address of the power_clock_control register on the special-function bus.
  localparam logic [7:0] PMR_ADDR = 8'hC4;
  // Value after reset: divide by 4, everything else off, low bits fixed at 1.
  localparam logic [7:0] PMR_RESET = 8'h83;
  // Field positions inside power_clock_control.
  localparam int DIV_HI_BIT = 7;
  localparam int DIV_LO_BIT = 6;
  localparam int SWB_BIT = 5;
  localparam int CTM_BIT = 4;
  localparam int RATE_BIT = 3;
  localparam int STROBE_SUPPRESS_BIT = 2;
  // The two lowest bits always read back as ones.
  localparam logic [1:0] RESERVED_BITS = 2'h3;
  // Clock-ready flag after reset.
  localparam logic READY_RESET = 1'h0;

  // ----------------------------------------------------------------------------
  // Divide field codes
  // ----------------------------------------------------------------------------
  localparam logic [1:0] DIV_MULT = 2'h0;
  localparam logic [1:0] DIV_RSVD = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  localparam logic [1:0] DIV_BY1024 = 2'h3;

  // ----------------------------------------------------------------------------
  // Cycle counts, in oscillator clocks
  // ----------------------------------------------------------------------------
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] MC_LEN_X1 = 12'h001;
  localparam logic [CNT_W-1:0] MC_LEN_X2 = 12'h002;
  localparam logic [CNT_W-1:0] MC_LEN_X4 = 12'h004;
  localparam logic [CNT_W-1:0] MC_LEN_SLOW = 12'h400;
  localparam logic [CNT_W-1:0] TIMER_LEN_LEGACY = 12'h00C;
  localparam logic [CNT_W-1:0] TIMER_LEN_SLOW = 12'hC00;
  localparam logic [CNT_W-1:0] SERIAL2_LEN = 12'h040;
  localparam logic [CNT_W-1:0] SERIAL2_LEN_FAST = 12'h020;

  // ----------------------------------------------------------------------------
  // Multiplier stabilisation time
  // ----------------------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 25;
  localparam int STAB_TIME_NS = 100000;
  // Least time, so round up to whole clock cycles.
  localparam int STAB_CYCLES = (STAB_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

endpackage

// [clock_warmup.sv]
// Stabilisation timer for the crystal clock multiplier.
// Assumes enable_i and start_i come from logic on mclk_i.
`timescale 1ns/100ps

module clock_warmup
  import clock_power_pkg::*;
#(
  parameter int STAB_CNT = STAB_CYCLES
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control from the register logic.
  input wire logic enable_i,
  input wire logic start_i,
  // Clock-ready indication.
  output logic ready_o
);

  // ----------------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------------
  // Cycles spent waiting since the multiplier was enabled.
  logic [CNT_W-1:0] cnt_reg;
  // Comparison against the last count of the stabilisation period.
  wire done = (cnt_reg == CNT_W'(STAB_CNT - 1));

  // A powered-down multiplier is never ready, so a disable also restarts the wait.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      ready_o <= READY_RESET;
    end else if (!enable_i || start_i) begin
      cnt_reg <= '0;
      ready_o <= 1'h0;
    end else if (!ready_o) begin
      if (done) begin
        ready_o <= 1'h1;
      end else begin
        cnt_reg <= cnt_reg + 1'h1;
      end
    end
  end

endmodule

// [cycle_divider.sv]
// Machine-cycle, timer and serial mode-2 tick generator.
// Assumes mclk_i is the oscillator clock and all selects are on its domain.
`timescale 1ns/100ps

module cycle_divider
  import clock_power_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Selects.
  input wire logic [1:0] divide_i,
  input wire logic rate_i,
  input wire logic timer_sel_i,
  input wire logic baud_doubler_i,
  // Ticks, one cycle wide; the machine tick, and the timer tick when it follows it, stay high at one clock per machine cycle.
  output logic mc_tick_o,
  output logic timer_tick_o,
  output logic serial2_tick_o
);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // A counter wraps when it reaches or passes its last count; passing covers a
  // shorter length being selected while the counter is already beyond it.
  function automatic logic wraps(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] len);
    wraps = (cnt >= len - 1'h1);
  endfunction

  // ----------------------------------------------------------------------------
  // Lengths
  // ----------------------------------------------------------------------------
  logic [CNT_W-1:0] mc_len;
  logic [CNT_W-1:0] mc_cnt_reg;
  logic [CNT_W-1:0] tm_cnt_reg;
  logic [CNT_W-1:0] sp_cnt_reg;

  // Oscillator clocks per machine cycle; the reserved code is never stored.
  always_comb begin
    case (divide_i)
      DIV_MULT: mc_len = rate_i ? MC_LEN_X1 : MC_LEN_X2;
      DIV_BY1024: mc_len = MC_LEN_SLOW;
      default: mc_len = MC_LEN_X4;
    endcase
  end

  // Legacy timer divide is 12 except in the slowest setting.
  wire [CNT_W-1:0] tm_len = (divide_i == DIV_BY1024) ? TIMER_LEN_SLOW : TIMER_LEN_LEGACY;
  // Serial mode 2 ignores the divide field entirely.
  wire [CNT_W-1:0] sp_len = baud_doubler_i ? SERIAL2_LEN_FAST : SERIAL2_LEN;
  wire mc_wrap = wraps(mc_cnt_reg, mc_len);
  wire tm_wrap = wraps(tm_cnt_reg, tm_len);
  wire sp_wrap = wraps(sp_cnt_reg, sp_len);

  // ----------------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------------
  // All three counters free-run; ticks are registered for clean outputs.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mc_cnt_reg <= '0;
      tm_cnt_reg <= '0;
      sp_cnt_reg <= '0;
      mc_tick_o <= 1'h0;
      timer_tick_o <= 1'h0;
      serial2_tick_o <= 1'h0;
    end else begin
      mc_cnt_reg <= mc_wrap ? '0 : mc_cnt_reg + 1'h1;
      tm_cnt_reg <= tm_wrap ? '0 : tm_cnt_reg + 1'h1;
      sp_cnt_reg <= sp_wrap ? '0 : sp_cnt_reg + 1'h1;
      mc_tick_o <= mc_wrap;
      timer_tick_o <= timer_sel_i ? mc_wrap : tm_wrap;
      serial2_tick_o <= sp_wrap;
    end
  end

endmodule

// [tb_top.sv]
// Self-checking bench for the machine-cycle divider and power-management block.
// Assumes the design package and all design modules are compiled before this file.
`timescale 1ns/100ps

module tb_top;
  import clock_power_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals and model state
  // ---------------------------------------------------------------------------
  // A short warm-up keeps the run brief; expectations follow this value.
  localparam int SC = 10;
  logic mclk_i, rst_n_i, sfr_wr_i, sfr_rd_i, stop_enter_i, ext_int_ack_i, serial_tx_start_i;
  logic rxd_i, instr_start_i, timer_clock_select_i, baud_doubler_i, ale_req_i, ext_mem_access_i;
  logic ring_osc_active_i;
  // Switchback source levels, driven from src below.
  logic ext_int_active_i, serial_tx_busy_i, serial_rx_busy_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [1:0] divide_sel_o;
  logic multiplier_enable_o, multiplier_rate_select_o, clock_ready_flag_o;
  logic machine_tick_o, timer_tick_o, serial2_tick_o, ale_o;
  // Switchback sources: pending interrupt, transmit busy, receive busy.
  logic [2:0] src;
  logic [31:0] seed;
  int err_total, n_checks, m_div, m_en, m_rate, m_swb, m_sup, m_rdy;
  assign ext_int_active_i = src[0];
  assign serial_tx_busy_i = src[1];
  assign serial_rx_busy_i = src[2];

  clock_divide_power_manager #(.STAB_CNT(SC)) u_clock_divide_power_manager (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .ring_osc_active_i(ring_osc_active_i), .stop_enter_i(stop_enter_i),
    .ext_int_active_i(ext_int_active_i), .ext_int_ack_i(ext_int_ack_i),
    .serial_tx_start_i(serial_tx_start_i), .serial_tx_busy_i(serial_tx_busy_i),
    .serial_rx_busy_i(serial_rx_busy_i), .rxd_i(rxd_i), .instr_start_i(instr_start_i),
    .timer_clock_select_i(timer_clock_select_i), .baud_doubler_i(baud_doubler_i),
    .ale_req_i(ale_req_i), .ext_mem_access_i(ext_mem_access_i), .divide_sel_o(divide_sel_o),
    .multiplier_enable_o(multiplier_enable_o), .multiplier_rate_select_o(multiplier_rate_select_o),
    .clock_ready_flag_o(clock_ready_flag_o), .machine_tick_o(machine_tick_o),
    .timer_tick_o(timer_tick_o), .serial2_tick_o(serial2_tick_o), .ale_o(ale_o));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Verdict and end of run, reached from the main sequence and from timeouts.
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Case equality, so an unknown never counts as a match.
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Fixed-seed xorshift source for random stimulus.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // One-cycle register read; data is settled by the following falling edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr_addr_i = a;
    sfr_rd_i = 1'h1;
    @(negedge mclk_i);
    sfr_rd_i = 1'h0;
    v = sfr_rdata_o;
  endtask

  // Compares the divide, enable and rate outputs and the readback against the model.
  task automatic cr();
    logic [7:0] v;
    chk("divide_sel", divide_sel_o, m_div);
    chk("multiplier_enable", multiplier_enable_o, m_en);
    chk("rate_select", multiplier_rate_select_o, m_rate);
    rd(PMR_ADDR, v);
    chk("readback", v, {m_div[1:0], m_swb[0], m_en[0], m_rate[0], m_sup[0], 2'h3});
  endtask

  // Register write; the model decides field by field what the write may change.
  task automatic wr(input logic [7:0] d);
    int nd;
    logic ok;
    nd = d[7:6];
    ok = nd != 1 && (nd == m_div || nd == 2 || m_div == 2);
    if (nd == 0 && (ring_osc_active_i || !m_en || !m_rdy)) ok = 0;
    if (nd == 3 && m_swb && src != 0) ok = 0;
    if (!m_en) m_rate = d[3];
    if (m_div == 2 && !ring_osc_active_i) begin
      if (d[4] && !m_en) m_rdy = 0;
      m_en = d[4];
    end
    if (ok) m_div = nd;
    m_swb = d[5];
    m_sup = d[2];
    sfr_addr_i = PMR_ADDR;
    sfr_wdata_i = d;
    sfr_wr_i = 1'h1;
    @(negedge mclk_i);
    sfr_wr_i = 1'h0;
    cr();
  endtask

  // Measures the spacing of one tick kind: 0 machine, 1 timer, 2 serial mode 2.
  task automatic per(input int sel, input int exp);
    int n;
    logic t;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge mclk_i);
        n++;
        t = sel == 0 ? machine_tick_o : (sel == 1 ? timer_tick_o : serial2_tick_o);
      end while (t !== 1'h1 && n < 3200);
      if (n >= 3200) begin
        err_total++;
        wrap_up();
      end
    end
    chk("tick_period", 12'(n), 12'(exp));
  endtask

  // Drives one strobe input high for a single cycle.
  task automatic pulse(input int w);
    if (w == 0) ext_int_ack_i = 1'h1;
    if (w == 1) serial_tx_start_i = 1'h1;
    if (w == 2) instr_start_i = 1'h1;
    if (w == 3) stop_enter_i = 1'h1;
    @(negedge mclk_i);
    {ext_int_ack_i, serial_tx_start_i, instr_start_i, stop_enter_i} = 4'h0;
  endtask

  // ---------------------------------------------------------------------------
  // Clock and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    mclk_i = 1'h0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  initial begin
    logic [7:0] v;
    logic [31:0] r;
    int n;
    {sfr_wr_i, sfr_rd_i, stop_enter_i, ext_int_ack_i, serial_tx_start_i, instr_start_i} = 6'h0;
    {ring_osc_active_i, ale_req_i, ext_mem_access_i, timer_clock_select_i} = 4'h0;
    {sfr_addr_i, sfr_wdata_i} = 16'h0;
    {rxd_i, baud_doubler_i} = 2'h3;
    src = 3'h0;
    seed = 32'h2D;
    {err_total, n_checks, m_en, m_rate, m_swb, m_sup, m_rdy} = '0;
    m_div = 2;
    rst_n_i = 1'h0;
    repeat (5) @(negedge mclk_i);
    rst_n_i = 1'h1;
    cr();
    wr(8'h43);
    wr(8'hC3);
    per(0, 1024);
    per(1, 3072);
    wr(8'h03);
    wr(8'h83);
    per(0, 4);
    per(1, 12);
    per(2, 32);
    baud_doubler_i = 1'h0;
    per(2, 64);
    timer_clock_select_i = 1'h1;
    per(1, 4);
    timer_clock_select_i = 1'h0;
    wr(8'h8B);
    ring_osc_active_i = 1'h1;
    repeat (4) @(negedge mclk_i);
    wr(8'h9B);
    wr(8'h1B);
    ring_osc_active_i = 1'h0;
    repeat (4) @(negedge mclk_i);
    wr(8'h9B);
    chk("ready_cleared", clock_ready_flag_o, 0);
    wr(8'h1B);
    n = 0;
    while (clock_ready_flag_o !== 1'h1 && n < SC + 6) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= SC + 6) begin
      err_total++;
      wrap_up();
    end
    m_rdy = 1;
    wr(8'h93);
    wr(8'h1B);
    per(0, 1);
    wr(8'h03);
    wr(8'h9B);
    pulse(3);
    m_en = 0;
    m_rdy = 0;
    cr();
    for (int i = 0; i < 3; i++) begin
      wr(8'hE3);
      if (i == 2) begin
        rxd_i = 1'h0;
        repeat (5) @(negedge mclk_i);
      end
      pulse(i);
      rxd_i = 1'h1;
      m_div = 2;
      cr();
    end
    for (int i = 0; i < 3; i++) begin
      src = 3'h1 << i;
      @(negedge mclk_i);
      wr(8'hE3);
      src = 3'h0;
    end
    wr(8'h87);
    for (int k = 0; k < 24; k++) begin
      if (k == 12) wr(8'h83);
      r = xs();
      ale_req_i = r[0];
      ext_mem_access_i = r[1];
      @(negedge mclk_i);
      chk("ale", ale_o, r[0] & (r[1] | !m_sup));
    end
    rd(8'hC5, v);
    chk("unmapped_read", v, 0);
    wrap_up();
  end
endmodule
